//--- logic/ccu_regs.svh
`ifndef CCU_REGS_SVH
`define CCU_REGS_SVH

// register byte offsets inside the block's window
`define CCU_OFS_CTRL     8'h00
`define CCU_OFS_SEED     8'h04
`define CCU_OFS_SUM      8'h08
`define CCU_OFS_DATA     8'h0c
`define CCU_OFS_STATUS   8'h10

// reset values
`define CCU_CTRL_RST     8'h00
`define CCU_SEED_RST     32'h0000_0000
`define CCU_RDATA_RST    32'h0000_0000

// generator polynomials, normal form without the leading term
`define CCU_POLY_CRC16   32'h0000_8005
`define CCU_POLY_CCITT   32'h0000_1021
`define CCU_POLY_CRC32   32'h04c1_1db7

// AHB-Lite codes
`define CCU_HSIZE_BYTE   3'h0
`define CCU_HSIZE_HALF   3'h1
`define CCU_HSIZE_WORD   3'h2
`define CCU_HRESP_OKAY   1'h0

// bytes per transfer size, minus one
`define CCU_NB1_BYTE     2'h0
`define CCU_NB1_HALF     2'h1
`define CCU_NB1_WORD     2'h3

`endif

//--- logic/ccu_pkg.sv
`default_nettype none

package ccu_pkg;

    typedef enum logic [1:0] {
        CCU_CRC16,
        CCU_CCITT,
        CCU_CRC32,
        CCU_RSVD
    } ccu_mode_t;

    // control register layout, msb first
    typedef struct packed {
        logic      sumCmpl;
        logic      sumByteRev;
        logic      sumBitRev;
        logic      datCmpl;
        logic      datByteRev;
        logic      datBitRev;
        ccu_mode_t mode;
    } ccu_ctrl_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  nbm1;
    } ccu_entry_t;

    typedef struct packed {
        logic       write;
        logic [7:0] ofs;
        logic [2:0] size;
    } ccu_xfer_t;

    typedef enum logic {
        CCU_BUS_IDLE,
        CCU_BUS_WAIT
    } ccu_bus_t;

endpackage

`default_nettype wire

//--- logic/ccu_top.sv
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ccu_regs.svh"

module ccu_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 16
) (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic                     inValid,
    input  wire logic [WIDTH-1:0]         inData,
    output logic                          inReady,
    output logic                          outValid,
    output logic [WIDTH-1:0]              outData,
    input  wire logic                     outReady,
    output logic [$clog2(DEPTH):0]        level
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
            $error("ccu_fifo depth must be a power of two of at least 2");
        end
        if (WIDTH < 1) begin : gBadWidth
            $error("ccu_fifo width must be positive");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;

    // extra pointer bit tells full from empty
    assign level    = wrPtr - rdPtr;
    assign inReady  = (level != (AW+1)'(DEPTH));
    assign outValid = (wrPtr != rdPtr);
    assign outData  = mem[rdPtr[AW-1:0]];

    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr <= '0;
        end else if (inValid && inReady) begin
            wrPtr <= wrPtr + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdPtr <= '0;
        end else if (outValid && outReady) begin
            rdPtr <= rdPtr + (AW+1)'(1);
        end
    end

    // storage holds data only, so it needs no reset
    always_ff @(posedge clk) begin
        if (inValid && inReady) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end
endmodule // ccu_fifo

module ccu_top #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    localparam int EW = $bits(ccu_pkg::ccu_entry_t);

    generate
        if (FIFO_DEPTH < 2) begin : gBadDepth
            $error("ccu_top needs a fifo depth of at least 2");
        end
    endgenerate

    ccu_pkg::ccu_bus_t   busState;
    ccu_pkg::ccu_xfer_t  xfer;
    ccu_pkg::ccu_ctrl_t  ctrl;
    ccu_pkg::ccu_entry_t pushEntry;
    ccu_pkg::ccu_entry_t headEntry;
    logic [31:0]         seed;
    logic [31:0]         crc;
    logic [31:0]         sumView;
    logic [31:0]         headShift;
    logic [31:0]         readMux;
    logic [23:0]         rem;
    logic [1:0]          cnt;
    logic [4:0]          headSh;
    logic [LW-1:0]       fifoLevel;
    logic                addrPhase;
    logic                busy;
    logic                canFinish;
    logic                finish;
    logic                pushValid;
    logic                fifoInReady;
    logic                fifoOutValid;
    logic                pop;
    logic                seedLoad;
    logic                is16;

    // size-dependent data or checksum transform over the low nb bytes
    function automatic logic [31:0] ccuXform(
        input logic [31:0] v,
        input int          nb,
        input logic        cmpl,
        input logic        byteRev,
        input logic        bitRev
    );
        logic [31:0] r;
        logic [7:0]  b;
        r = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            b = 8'h00;
            if (i < nb) begin
                b = byteRev ? v[8*(nb-1-i) +: 8] : v[8*i +: 8];
                if (bitRev) begin
                    b = {<<{b}};
                end
                if (cmpl) begin
                    b = ~b;
                end
            end
            r[8*i +: 8] = b;
        end
        return r;
    endfunction

    // one byte, msb first, into the remainder
    function automatic logic [31:0] ccuStep8(
        input logic [31:0]        c0,
        input logic [7:0]         d,
        input ccu_pkg::ccu_mode_t m
    );
        logic [31:0] c;
        logic [31:0] poly;
        logic        fb;
        logic        w16;
        c    = c0;
        w16  = (m == ccu_pkg::CCU_CRC16) || (m == ccu_pkg::CCU_CCITT);
        case (m)
            ccu_pkg::CCU_CRC16: poly = `CCU_POLY_CRC16;
            ccu_pkg::CCU_CCITT: poly = `CCU_POLY_CCITT;
            default:            poly = `CCU_POLY_CRC32;
        endcase
        for (int k = 7; k >= 0; k--) begin
            fb = (w16 ? c[15] : c[31]) ^ d[k];
            c  = {c[30:0], 1'b0};
            if (fb) begin
                c = c ^ poly;
            end
        end
        if (w16) begin
            c[31:16] = 16'h0000;
        end
        return c;
    endfunction

    assign is16      = (ctrl.mode == ccu_pkg::CCU_CRC16) ||
                       (ctrl.mode == ccu_pkg::CCU_CCITT);
    assign addrPhase = hsel && htrans[1] && hready;
    assign busy      = fifoOutValid || (cnt != 2'h0);

    // stalls keep ctrl and the remainder stable under queued data
    always_comb begin
        canFinish = 1'b1;
        case (xfer.ofs)
            `CCU_OFS_DATA: begin
                if (xfer.write) begin
                    canFinish = fifoInReady;
                end
            end
            `CCU_OFS_SUM: begin
                if (!xfer.write) begin
                    canFinish = !busy;
                end
            end
            `CCU_OFS_CTRL,
            `CCU_OFS_SEED: begin
                if (xfer.write) begin
                    canFinish = !busy;
                end
            end
            default: canFinish = 1'b1;
        endcase
    end

    assign finish    = (busState == ccu_pkg::CCU_BUS_WAIT) && canFinish;
    assign pushValid = (busState == ccu_pkg::CCU_BUS_WAIT) && xfer.write &&
                       (xfer.ofs == `CCU_OFS_DATA);
    assign seedLoad  = finish && xfer.write && (xfer.ofs == `CCU_OFS_SEED);

    always_comb begin
        pushEntry.nbm1 = `CCU_NB1_WORD;
        case (xfer.size)
            `CCU_HSIZE_BYTE: pushEntry.nbm1 = `CCU_NB1_BYTE;
            `CCU_HSIZE_HALF: pushEntry.nbm1 = `CCU_NB1_HALF;
            default:         pushEntry.nbm1 = `CCU_NB1_WORD;
        endcase
        pushEntry.data = ccuXform(hwdata, int'(pushEntry.nbm1) + 1,
                                  ctrl.datCmpl, ctrl.datByteRev,
                                  ctrl.datBitRev);
    end

    assign sumView = ccuXform(crc, is16 ? 2 : 4, ctrl.sumCmpl,
                              ctrl.sumByteRev, ctrl.sumBitRev);

    always_comb begin
        case (xfer.ofs)
            `CCU_OFS_CTRL:   readMux = {24'h00_0000, ctrl};
            `CCU_OFS_SEED:   readMux = seed;
            `CCU_OFS_SUM:    readMux = sumView;
            `CCU_OFS_STATUS: readMux = 32'({fifoLevel, busy});
            default:         readMux = `CCU_RDATA_RST;
        endcase
    end

    // every transfer takes at least one wait state so that hreadyout is a flop
    always_ff @(posedge clk) begin
        if (srst) begin
            busState  <= ccu_pkg::CCU_BUS_IDLE;
            hreadyout <= 1'b1;
            xfer      <= '0;
        end else begin
            case (busState)
                ccu_pkg::CCU_BUS_IDLE: begin
                    if (addrPhase) begin
                        xfer.write <= hwrite;
                        xfer.ofs   <= haddr[7:0];
                        xfer.size  <= hsize;
                        hreadyout  <= 1'b0;
                        busState   <= ccu_pkg::CCU_BUS_WAIT;
                    end
                end
                ccu_pkg::CCU_BUS_WAIT: begin
                    if (canFinish) begin
                        hreadyout <= 1'b1;
                        busState  <= ccu_pkg::CCU_BUS_IDLE;
                    end
                end
                default: begin
                    hreadyout <= 1'b1;
                    busState  <= ccu_pkg::CCU_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hrdata <= `CCU_RDATA_RST;
        end else if (finish && !xfer.write) begin
            hrdata <= readMux;
        end
    end

    always_ff @(posedge clk) begin
        hresp <= `CCU_HRESP_OKAY;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= ccu_pkg::ccu_ctrl_t'(`CCU_CTRL_RST);
        end else if (finish && xfer.write && xfer.ofs == `CCU_OFS_CTRL) begin
            ctrl <= ccu_pkg::ccu_ctrl_t'(hwdata[7:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            seed <= `CCU_SEED_RST;
        end else if (seedLoad) begin
            seed <= hwdata;
        end
    end

    ccu_fifo #(
        .WIDTH (EW),
        .DEPTH (FIFO_DEPTH)
    ) uFifo (
        .clk      (clk),
        .srst     (srst),
        .inValid  (pushValid),
        .inData   (pushEntry),
        .inReady  (fifoInReady),
        .outValid (fifoOutValid),
        .outData  (headEntry),
        .outReady (pop),
        .level    (fifoLevel)
    );

    // first byte of an entry folds in the pop cycle, then one per cycle
    assign pop       = fifoOutValid && (cnt == 2'h0);
    assign headSh    = {2'(2'h3 - headEntry.nbm1), 3'h0};
    assign headShift = headEntry.data << headSh;

    always_ff @(posedge clk) begin
        if (srst) begin
            crc <= `CCU_SEED_RST;
            rem <= 24'h00_0000;
            cnt <= 2'h0;
        end else if (seedLoad) begin
            crc <= is16 ? {16'h0000, hwdata[15:0]} : hwdata;
        end else if (cnt != 2'h0) begin
            crc <= ccuStep8(crc, rem[23:16], ctrl.mode);
            rem <= {rem[15:0], 8'h00};
            cnt <= cnt - 2'h1;
        end else if (pop) begin
            crc <= ccuStep8(crc, headShift[31:24], ctrl.mode);
            rem <= headShift[23:0];
            cnt <= headEntry.nbm1;
        end
    end

    default clocking cbMain @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence sDrainWord;
        (cnt == 2'h3) ##1 (cnt == 2'h2) ##1 (cnt == 2'h1) ##1 (cnt == 2'h0);
    endsequence

    sequence sDrainHalf;
        (cnt == 2'h1) ##1 (cnt == 2'h0);
    endsequence

    sequence sReadSumBusy;
        (busState == ccu_pkg::CCU_BUS_WAIT) && !xfer.write &&
        (xfer.ofs == `CCU_OFS_SUM) && busy;
    endsequence

    AST_POLY_CRC16: assert property (
        pop && crc == 32'h0000_0000 && headShift[31:24] == 8'h01 &&
        ctrl.mode == ccu_pkg::CCU_CRC16 |=> crc == `CCU_POLY_CRC16)
        else $error("crc16 step gave wrong polynomial");

    AST_POLY_CCITT: assert property (
        pop && crc == 32'h0000_0000 && headShift[31:24] == 8'h01 &&
        ctrl.mode == ccu_pkg::CCU_CCITT |=> crc == `CCU_POLY_CCITT)
        else $error("ccitt step gave wrong polynomial");

    AST_POLY_CRC32: assert property (
        pop && crc == 32'h0000_0000 && headShift[31:24] == 8'h01 &&
        ctrl.mode == ccu_pkg::CCU_CRC32 |=> crc == `CCU_POLY_CRC32)
        else $error("crc32 step gave wrong polynomial");

    AST_DATA_CMPL: assert property (
        pushValid && fifoInReady && ctrl.datCmpl && !ctrl.datByteRev &&
        !ctrl.datBitRev && pushEntry.nbm1 == `CCU_NB1_BYTE |->
        pushEntry.data == {24'h00_0000, ~hwdata[7:0]})
        else $error("byte data complement wrong");

    AST_SUM_CMPL: assert property (
        ctrl.sumCmpl && !ctrl.sumByteRev && !ctrl.sumBitRev && !is16 |->
        sumView == ~crc)
        else $error("checksum complement wrong");

    AST_HALF_SIZE: assert property (
        pushValid && fifoInReady && xfer.size == `CCU_HSIZE_HALF |->
        pushEntry.nbm1 == `CCU_NB1_HALF)
        else $error("half-word write not queued as two bytes");

    AST_SEED_LOAD: assert property (
        seedLoad && !is16 |=> crc == $past(hwdata) && cnt == 2'h0)
        else $error("seed not loaded into remainder");

    AST_BYTE_ONE: assert property (
        pop && headEntry.nbm1 == `CCU_NB1_BYTE |=> cnt == 2'h0)
        else $error("byte update took more than one cycle");

    AST_WORD_FOUR: assert property (
        pop && headEntry.nbm1 == `CCU_NB1_WORD |=> sDrainWord)
        else $error("word update not done in four cycles");

    AST_FIFO_STALL: assert property (
        pushValid && !fifoInReady |=>
        !hreadyout && busState == ccu_pkg::CCU_BUS_WAIT)
        else $error("full fifo did not stall the bus");

    AST_SUM_WIDTH: assert property (
        finish && !xfer.write && xfer.ofs == `CCU_OFS_SUM && is16 |=>
        hrdata[31:16] == 16'h0000 && hreadyout)
        else $error("16-bit checksum has upper bits set");

    AST_HALF_TWO: assert property (
        pop && headEntry.nbm1 == `CCU_NB1_HALF |=> sDrainHalf)
        else $error("half-word update not done in two cycles");

    AST_SUM_WAIT: assert property (
        sReadSumBusy |=> !hreadyout)
        else $error("checksum read completed while busy");
endmodule // ccu_top

`default_nettype wire

//--- verification/ccu_ahb_master.sv
`timescale 1ns/10ps
`default_nettype none

module ccu_ahb_master (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // enter just after a rising edge; returns at the edge ending the data
    task automatic xfer(input logic wr, input logic [7:0] ofs,
                        input logic [2:0] sz, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, ofs};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= sz;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        haddr  <= ~{24'h00_0000, ofs};
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        // released data lanes must not keep the last value
        hwdata <= ~wd;
    endtask
endmodule // ccu_ahb_master

`default_nettype wire

//--- verification/crc_calc_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccu_regs.svh"
`define CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
end

module crc_calc_unit_tb;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [7:0]  ctrl = 8'h00;
    logic [31:0] rem = 32'h0000_0000;
    logic [31:0] rd;
    int          n_fail = 0;
    int          n_tests = 0;

    always #12.5 clk = ~clk;

    ccu_top #(.FIFO_DEPTH(16)) dut_u (
        .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp)
    );

    ccu_ahb_master bus_u (
        .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata)
    );

    function automatic int wid(logic [7:0] c);
        return c[1] ? 32 : 16;
    endfunction

    function automatic logic [31:0] msk(int n);
        return (n == 32) ? 32'hffff_ffff : ((32'h0000_0001 << n) - 1);
    endfunction

    function automatic logic [31:0] brev(logic [31:0] v, int nb);
        logic [31:0] r = 32'h0000_0000;
        for (int k = 0; k < nb; k++) r[8*k +: 8] = v[8*(nb-1-k) +: 8];
        return r;
    endfunction

    function automatic logic [31:0] bitr(logic [31:0] v, int n);
        logic [31:0] r = 32'h0000_0000;
        for (int j = 0; j < n; j++) r[j] = v[n-1-j];
        return r;
    endfunction

    function automatic logic [31:0] xdat(logic [31:0] v, int nb,
                                         logic [7:0] c);
        logic [31:0] r;
        r = (c[4] ? ~v : v) & msk(8 * nb);
        if (c[3]) r = brev(r, nb);
        if (c[2])
            for (int k = 0; k < nb; k++)
                r[8*k +: 8] = 8'(bitr({24'h00_0000, r[8*k +: 8]}, 8));
        return r;
    endfunction

    function automatic logic [31:0] fold(logic [31:0] r, logic [7:0] b,
                                         logic [7:0] c);
        logic [31:0] p;
        logic        fb;
        p = c[1] ? `CCU_POLY_CRC32 : (c[0] ? `CCU_POLY_CCITT
                                           : `CCU_POLY_CRC16);
        for (int j = 7; j >= 0; j--) begin
            fb = r[wid(c)-1] ^ b[j];
            r = (r << 1) & msk(wid(c));
            if (fb) r = r ^ p;
        end
        return r;
    endfunction

    function automatic logic [31:0] sumx(logic [31:0] r, logic [7:0] c);
        logic [31:0] s;
        s = r & msk(wid(c));
        if (c[7]) s = ~s & msk(wid(c));
        if (c[6]) s = brev(s, wid(c) / 8);
        // sum bit reversal stays inside each byte, as on the data side
        if (c[5])
            for (int k = 0; k < wid(c) / 8; k++)
                s[8*k +: 8] = 8'(bitr({24'h00_0000, s[8*k +: 8]}, 8));
        return s;
    endfunction

    task automatic acc(logic wr, logic [7:0] ofs, logic [2:0] sz,
                       logic [31:0] wd);
        bus_u.xfer(wr, ofs, sz, wd, rd);
        `CHK("hresp", `CCU_HRESP_OKAY, hresp)
    endtask

    task automatic rchk(logic [7:0] ofs, logic [31:0] e, string nm);
        acc(1'b0, ofs, `CCU_HSIZE_WORD, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask

    task automatic wctrl(logic [7:0] c);
        acc(1'b1, `CCU_OFS_CTRL, `CCU_HSIZE_WORD, {24'h00_0000, c});
        ctrl = c;
    endtask

    task automatic wseed(logic [31:0] s);
        acc(1'b1, `CCU_OFS_SEED, `CCU_HSIZE_WORD, s);
        rem = s & msk(wid(ctrl));
    endtask

    task automatic wdat(logic [2:0] sz, logic [31:0] v);
        int          nb;
        logic [31:0] x;
        nb = (sz == `CCU_HSIZE_BYTE) ? 1 : (sz == `CCU_HSIZE_HALF) ? 2 : 4;
        acc(1'b1, `CCU_OFS_DATA, sz, v & msk(8 * nb));
        x = xdat(v, nb, ctrl);
        for (int k = nb - 1; k >= 0; k--) rem = fold(rem, x[8*k +: 8], ctrl);
    endtask

    task automatic t_reset();
        rchk(`CCU_OFS_CTRL, {24'h00_0000, `CCU_CTRL_RST}, "ctrl");
        rchk(`CCU_OFS_SEED, `CCU_SEED_RST, "seed");
        rchk(`CCU_OFS_SUM, `CCU_RDATA_RST, "sum");
        rchk(`CCU_OFS_STATUS, 32'h0000_0000, "status");
        acc(1'b1, 8'h20, `CCU_HSIZE_WORD, 32'hdead_beef);
        rchk(8'h20, 32'h0000_0000, "unmapped");
        acc(1'b1, `CCU_OFS_DATA, `CCU_HSIZE_WORD, 32'h0000_0000);
        rchk(`CCU_OFS_DATA, 32'h0000_0000, "data read");
        $display("t_reset done");
    endtask

    // known check values over the ascii digits 1..9
    task automatic t_known();
        logic [7:0]  cs [3] = '{8'h00, 8'h01, 8'h82};
        logic [31:0] sd [3] = '{32'h0000_0000, 32'h0000_ffff, 32'hffff_ffff};
        logic [31:0] ex [3] = '{32'h0000_fee8, 32'h0000_29b1, 32'hfc89_1918};
        for (int m = 0; m < 3; m++) begin
            wctrl(cs[m]);
            wseed(sd[m]);
            for (int i = 0; i < 9; i++) wdat(`CCU_HSIZE_BYTE, 32'h31 + i);
            rchk(`CCU_OFS_SUM, ex[m], "known sum");
        end
        $display("t_known done");
    endtask

    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wctrl(8'(m));
            wseed(32'h89ab_cdef);
            rchk(`CCU_OFS_SEED, 32'h89ab_cdef, "seed");
            wdat(`CCU_HSIZE_WORD, 32'h1234_5678);
            wdat(`CCU_HSIZE_HALF, 32'h0000_beef);
            wdat(`CCU_HSIZE_BYTE, 32'h0000_005a);
            rchk(`CCU_OFS_SUM, sumx(rem, ctrl), "mode sum");
            // a single one bit from a zero seed leaves the polynomial
            wseed(32'h0000_0000);
            wdat(`CCU_HSIZE_BYTE, 32'h0000_0001);
            rchk(`CCU_OFS_SUM, sumx(rem, ctrl), "poly sum");
        end
        $display("t_modes done");
    endtask

    task automatic t_xform();
        for (int m = 0; m < 3; m += 2)
            for (int b = 2; b < 8; b++) begin
                wctrl(8'(m) | (8'h01 << b));
                rchk(`CCU_OFS_CTRL, {24'h00_0000, ctrl}, "ctrl");
                wseed(32'h1d0f_a5c3);
                wdat(`CCU_HSIZE_WORD, 32'h1234_5678);
                wdat(`CCU_HSIZE_HALF, 32'h0000_a1b2);
                wdat(`CCU_HSIZE_BYTE, 32'h0000_00c5);
                rchk(`CCU_OFS_SUM, sumx(rem, ctrl), "xform sum");
            end
        $display("t_xform done");
    endtask

    // status right after a write shows how long the fold takes
    task automatic t_timing();
        logic [2:0] sz [3] = '{`CCU_HSIZE_BYTE, `CCU_HSIZE_HALF,
                               `CCU_HSIZE_WORD};
        logic [1:0] bz [3] = '{2'b00, 2'b00, 2'b10};
        wctrl(8'h02);
        for (int i = 0; i < 3; i++) begin
            wdat(sz[i], 32'hc3a5_5a3c);
            rchk(`CCU_OFS_STATUS, {31'h0, bz[i][1]}, "busy 1st");
            rchk(`CCU_OFS_STATUS, {31'h0, bz[i][0]}, "busy 2nd");
            rchk(`CCU_OFS_STATUS, 32'h0000_0000, "busy 3rd");
        end
        rchk(`CCU_OFS_SUM, sumx(rem, ctrl), "timing sum");
        $display("t_timing done");
    endtask

    // writes outpace the fold, so the queue fills and stalls the bus
    task automatic t_fifo();
        wctrl(8'h02);
        wseed(32'hffff_ffff);
        for (int i = 0; i < 80; i++) wdat(`CCU_HSIZE_WORD, 32'h0101_0101 * i);
        acc(1'b0, `CCU_OFS_STATUS, `CCU_HSIZE_WORD, 32'h0000_0000);
        `CHK("busy", 1'b1, rd[0])
        `CHK("level high", 1'b1, rd[5:1] >= 5'd12)
        rchk(`CCU_OFS_SUM, sumx(rem, ctrl), "block sum");
        rchk(`CCU_OFS_STATUS, 32'h0000_0000, "drained");
        $display("t_fifo done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_known();
        t_modes();
        t_xform();
        t_timing();
        t_fifo();
        results();
    end
endmodule // crc_calc_unit_tb

`default_nettype wire
